// >>> core/dmb_mailbox.sv
// Purpose: Host/coprocessor mailbox bytes plus coprocessor interrupt control
// Assumes: Both processors access on clk_sys with single-cycle strobes
// Notes:   Service state ends on coproc_isr_done from the coprocessor core
`timescale 1ns/100ps
`default_nettype none
`include "dmb_consts.svh"

// Behaviour
// - Eight host read-write outgoing bytes, coprocessor reads
// - Eight incoming bytes, host read-only, writes ignored
// - Bytes pair into four 16-bit words, even high
// - Port read gives outgoing pair, write fills incoming
// - Highest ranked pending enabled request served first
// - No new interrupt while one is in service
// - Bits f,e,d pending; write one clears
// - Clear bits unstored, reads return pending status
// - Bits c,b,a are per-input enables for high, mid, low after routing
// - Bit 8 global enable, cleared at reset
// - Doorbell set by host only, cleared by coprocessor
// - Conversion done sets analog-input flag until cleared
// - Third timer event sets analog-output flag
// - Bit 9 reads host request, write one sets
// - Host acknowledge clears host request three instructions later
// - Bits 7 to 5 select source routing
// - Route codes map sources to high/mid/low inputs
// - Host control bit 1 sets doorbell, reads state
module dmb_mailbox
   import dmb_pkg::*;
(
   // System
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // Host bank B mailbox access
   input  wire logic        host_mb_wr,
   input  wire logic        host_mb_rd,
   input  wire logic [3:0]  host_mb_addr,
   input  wire logic [7:0]  host_mb_wdata,
   output logic      [7:0]  host_mb_rdata,
   // Host bank F control access
   input  wire logic        host_ctrl_wr,
   input  wire logic        host_ctrl_rd,
   input  wire logic [3:0]  host_ctrl_addr,
   input  wire logic [7:0]  host_ctrl_wdata,
   output logic      [7:0]  host_ctrl_rdata,
   input  wire logic        host_instr_done,
   output logic             host_doorbell_request,
   // Coprocessor port access
   input  wire logic        coproc_wr,
   input  wire logic        coproc_rd,
   input  wire logic [2:0]  coproc_addr,
   input  wire logic [15:0] coproc_wdata,
   output logic      [15:0] coproc_rdata,
   // Interrupt sources and service
   input  wire logic        adc_done,
   input  wire logic        third_timer,
   input  wire logic        coproc_isr_done,
   output logic             coproc_irq_take,
   output logic      [1:0]  coproc_irq_vector,
   output logic             coproc_in_service
);

   logic [7:0]  out_bytes [0:7];
   logic [7:0]  in_bytes  [0:7];
   logic        host_to_coproc_doorbell;
   logic        adc_done_flag;
   logic        dac_tick_flag;
   logic [2:0]  irq_enable;
   logic        global_enable;
   logic [2:0]  irq_route_select;
   logic [1:0]  ack_count;
   logic        ack_busy;
   dmb_state_t  state;
   logic [2:0]  raw_irq;
   logic [2:0]  gated_irq;
   logic        icr_wr;
   logic [2:0]  pending_clear_strobe;

   // Mailbox word at port n covers byte 2n (high) and 2n+1 (low)
   function automatic logic [2:0] pair_base(input logic [1:0] port);
      pair_base = {port, 1'b0};
   endfunction

   function automatic logic [2:0] pair_next(input logic [1:0] port);
      pair_next = {port, 1'b1};
   endfunction

   assign icr_wr = coproc_wr && (coproc_addr == `DMB_PORT_ICR);
   assign pending_clear_strobe = icr_wr ? coproc_wdata[`DMB_ICR_PEND_HI:`DMB_ICR_PEND_LO] : 3'h0;

   // Outgoing bytes, host owned; whole byte per write
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         for (int i = 0; i < 8; i++) begin
            out_bytes[i] <= 8'h00;
         end
      end else if (host_mb_wr && !host_mb_addr[3]) begin
         out_bytes[host_mb_addr[2:0]] <= host_mb_wdata;
      end
   end

   // Incoming bytes, coprocessor owned; host writes land nowhere
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         for (int i = 0; i < 8; i++) begin
            in_bytes[i] <= 8'h00;
         end
      end else if (coproc_wr && !coproc_addr[2]) begin
         in_bytes[pair_base(coproc_addr[1:0])] <= coproc_wdata[15:8];
         in_bytes[pair_next(coproc_addr[1:0])] <= coproc_wdata[7:0];
      end
   end

   // Registered reads: the value sampled is the one before any same-edge write
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         host_mb_rdata <= 8'h00;
      end else if (host_mb_rd) begin
         host_mb_rdata <= host_mb_addr[3] ? in_bytes[host_mb_addr[2:0]] : out_bytes[host_mb_addr[2:0]];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         coproc_rdata <= 16'h0000;
      end else if (coproc_rd) begin
         if (!coproc_addr[2]) begin
            coproc_rdata <= {out_bytes[pair_base(coproc_addr[1:0])],
                             out_bytes[pair_next(coproc_addr[1:0])]};
         end else if (coproc_addr == `DMB_PORT_ICR) begin
            coproc_rdata <= {host_to_coproc_doorbell, adc_done_flag, dac_tick_flag,
                             irq_enable, host_doorbell_request, global_enable,
                             irq_route_select, 5'h00};
         end else begin
            coproc_rdata <= 16'h0000;
         end
      end
   end

   // Host control register: bit 1 doorbell, bit 0 host request
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         host_ctrl_rdata <= 8'h00;
      end else if (host_ctrl_rd) begin
         host_ctrl_rdata <= (host_ctrl_addr == `DMB_HOST_CTRL_LOC) ?
                            {6'h00, host_to_coproc_doorbell, host_doorbell_request} : 8'h00;
      end
   end

   // Pending flags; a set in the same cycle as a clear wins
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         host_to_coproc_doorbell <= 1'b0;
      end else if (host_ctrl_wr && host_ctrl_addr == `DMB_HOST_CTRL_LOC && host_ctrl_wdata[`DMB_HOST_CTRL_BELL]) begin
         host_to_coproc_doorbell <= 1'b1;
      end else if (pending_clear_strobe[2]) begin
         host_to_coproc_doorbell <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         adc_done_flag <= 1'b0;
      end else if (adc_done) begin
         adc_done_flag <= 1'b1;
      end else if (pending_clear_strobe[1]) begin
         adc_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         dac_tick_flag <= 1'b0;
      end else if (third_timer) begin
         dac_tick_flag <= 1'b1;
      end else if (pending_clear_strobe[0]) begin
         dac_tick_flag <= 1'b0;
      end
   end

   // Stored control fields of the interrupt control register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_enable       <= 3'h0;
         global_enable    <= 1'b0;
         irq_route_select <= 3'h0;
      end else if (icr_wr) begin
         irq_enable       <= coproc_wdata[`DMB_ICR_EN_HI:`DMB_ICR_EN_LO];
         global_enable    <= coproc_wdata[`DMB_ICR_GLOBAL_EN];
         irq_route_select <= coproc_wdata[`DMB_ICR_SEL_MSB:`DMB_ICR_SEL_LSB];
      end
   end

   // Host request: set by coprocessor, cleared after three host instructions
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ack_busy  <= 1'b0;
         ack_count <= 2'h0;
      end else if (host_ctrl_wr && host_ctrl_addr == `DMB_HOST_CTRL_LOC && host_ctrl_wdata[`DMB_HOST_CTRL_ACK]) begin
         ack_busy  <= 1'b1;
         ack_count <= 2'h0;
      end else if (ack_busy && host_instr_done) begin
         ack_count <= ack_count + 2'h1;
         if (ack_count == `DMB_ACK_DELAY - 2'h1) begin
            ack_busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         host_doorbell_request <= 1'b0;
      end else if (icr_wr && coproc_wdata[`DMB_ICR_HOST_REQ]) begin
         host_doorbell_request <= 1'b1;
      end else if (ack_busy && host_instr_done && ack_count == `DMB_ACK_DELAY - 2'h1) begin
         host_doorbell_request <= 1'b0;
      end
   end

   // Routing: raw_irq is {high, mid, low}; sources doorbell/adc/dac
   always_comb begin
      case (dmb_route_t'(irq_route_select))
         DMB_RT_BCO: raw_irq = {host_to_coproc_doorbell, adc_done_flag, dac_tick_flag};
         DMB_RT_CBO: raw_irq = {adc_done_flag, host_to_coproc_doorbell, dac_tick_flag};
         DMB_RT_BOC: raw_irq = {host_to_coproc_doorbell, dac_tick_flag, adc_done_flag};
         DMB_RT_COB: raw_irq = {adc_done_flag, dac_tick_flag, host_to_coproc_doorbell};
         DMB_RT_OBC: raw_irq = {dac_tick_flag, host_to_coproc_doorbell, adc_done_flag};
         DMB_RT_OCB: raw_irq = {dac_tick_flag, adc_done_flag, host_to_coproc_doorbell};
         // Reserved codes route nothing rather than guess
         default:    raw_irq = 3'h0;
      endcase
   end

   assign gated_irq = (global_enable && state == DMB_ST_IDLE) ? (raw_irq & irq_enable) : 3'h0;

   assign coproc_irq_take   = |gated_irq;
   assign coproc_in_service = (state == DMB_ST_SERV);

   // Service tracking and priority pick
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state             <= DMB_ST_IDLE;
         coproc_irq_vector <= 2'h0;
      end else begin
         case (state)
            DMB_ST_IDLE: begin
               if (coproc_irq_take) begin
                  state <= DMB_ST_SERV;
                  coproc_irq_vector <= gated_irq[2] ? 2'h2 : (gated_irq[1] ? 2'h1 : 2'h0);
               end
            end
            DMB_ST_SERV: begin
               if (coproc_isr_done) begin
                  state <= DMB_ST_IDLE;
               end
            end
            default: state <= DMB_ST_IDLE;
         endcase
      end
   end

   a_no_nesting: assert property (@(posedge clk_sys) disable iff (!resetn)
      coproc_in_service |-> !coproc_irq_take)
      else $error("interrupt taken during service");

   a_priority_pick: assert property (@(posedge clk_sys) disable iff (!resetn)
      (coproc_irq_take && gated_irq[2]) |=> (coproc_irq_vector == 2'h2 && coproc_in_service))
      else $error("high request not picked first");

   a_global_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
      !global_enable |-> !coproc_irq_take)
      else $error("interrupt taken while globally disabled");

   a_adc_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
      adc_done |=> adc_done_flag)
      else $error("conversion flag not set");

   a_clear_pend: assert property (@(posedge clk_sys) disable iff (!resetn)
      (pending_clear_strobe[0] && !third_timer) |=> !dac_tick_flag)
      else $error("output flag not cleared");

   a_flag_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
      (dac_tick_flag && !pending_clear_strobe[0]) |=> dac_tick_flag)
      else $error("output flag dropped without clear");

   a_host_req_set: assert property (@(posedge clk_sys) disable iff (!resetn)
      (icr_wr && coproc_wdata[9]) |=> host_doorbell_request)
      else $error("host request not raised");

   a_bell_host_only: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(host_to_coproc_doorbell) |-> $past(host_ctrl_wr))
      else $error("doorbell set without host write");

   a_mailbox_pair: assert property (@(posedge clk_sys) disable iff (!resetn)
      (coproc_wr && coproc_addr == 3'h1) |=> (in_bytes[2] == $past(coproc_wdata[15:8])))
      else $error("mailbox high byte misplaced");

   // Clear checks exclude a same-cycle set, which wins
   a_vector_held: assert property (@(posedge clk_sys) disable iff (!resetn)
      (coproc_in_service && !coproc_isr_done) |=> (coproc_in_service && $stable(coproc_irq_vector)))
      else $error("vector moved during service");

   a_mid_pick: assert property (@(posedge clk_sys) disable iff (!resetn)
      (coproc_irq_take && !gated_irq[2] && gated_irq[1]) |=> (coproc_irq_vector == 2'h1))
      else $error("middle request not picked");

   a_low_pick: assert property (@(posedge clk_sys) disable iff (!resetn)
      (coproc_irq_take && gated_irq == 3'h1) |=> (coproc_irq_vector == 2'h0))
      else $error("low request not picked");

   a_reset_global: assert property (@(posedge clk_sys) disable iff (!resetn)
      !$past(resetn) |-> !global_enable)
      else $error("global enable set after reset");

   a_adc_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
      (pending_clear_strobe[1] && !adc_done) |=> !adc_done_flag)
      else $error("conversion flag not cleared");

   a_bell_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
      (pending_clear_strobe[2] && !host_ctrl_wr) |=> !host_to_coproc_doorbell)
      else $error("doorbell not cleared");

   a_host_req_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ack_busy && host_instr_done && ack_count == `DMB_ACK_DELAY - 2'h1 && !icr_wr) |=> !host_doorbell_request)
      else $error("host request not cleared after acknowledge");

   a_ctrl_readback: assert property (@(posedge clk_sys) disable iff (!resetn)
      (host_ctrl_rd && host_ctrl_addr == `DMB_HOST_CTRL_LOC) |=>
         (host_ctrl_rdata[1] == $past(host_to_coproc_doorbell)))
      else $error("doorbell readback wrong");

   a_incoming_readonly: assert property (@(posedge clk_sys) disable iff (!resetn)
      (host_mb_wr && host_mb_addr == `DMB_IN_FIRST && !coproc_wr) |=> $stable(in_bytes[0]))
      else $error("host write changed an incoming byte");

   a_mailbox_low: assert property (@(posedge clk_sys) disable iff (!resetn)
      (coproc_wr && coproc_addr == 3'h1) |=> (in_bytes[3] == $past(coproc_wdata[7:0])))
      else $error("mailbox low byte misplaced");

   a_reserved_route: assert property (@(posedge clk_sys) disable iff (!resetn)
      (irq_route_select == 3'h6 || irq_route_select == 3'h7) |-> !coproc_irq_take)
      else $error("reserved route raised an interrupt");

endmodule
`default_nettype wire

// >>> inc/dmb_consts.svh
// Purpose: Constants for the dual processor mailbox and interrupt block
// Assumes: Byte host bus, 16-bit coprocessor port bus
// Notes:   Offsets are host bank locations and coprocessor port numbers
`ifndef DMB_CONSTS_SVH
`define DMB_CONSTS_SVH

// Host bank B mailbox locations
`define DMB_OUT_FIRST        4'h0
`define DMB_IN_FIRST         4'h8
// Host bank F control location
`define DMB_HOST_CTRL_LOC    4'hc
`define DMB_HOST_CTRL_ACK    0
`define DMB_HOST_CTRL_BELL   1
// Coprocessor port numbers
`define DMB_PORT_ICR         3'h4
// Control register fields
`define DMB_ICR_PEND_HI      15
`define DMB_ICR_PEND_MID     14
`define DMB_ICR_PEND_LO      13
`define DMB_ICR_EN_HI        12
`define DMB_ICR_EN_MID       11
`define DMB_ICR_EN_LO        10
`define DMB_ICR_HOST_REQ     9
`define DMB_ICR_GLOBAL_EN    8
`define DMB_ICR_SEL_MSB      7
`define DMB_ICR_SEL_LSB      5
// Acknowledge-to-clear delay in host instruction slots
`define DMB_ACK_DELAY        2'h3

`endif

// >>> inc/dmb_pkg.sv
// Purpose: Types for the dual processor mailbox block
// Assumes: Nothing beyond the constants header
// Notes:   Route codes above five are reserved
`default_nettype none
package dmb_pkg;
   // Letters name the sources on high, mid, low in that order
   typedef enum logic [2:0] {
      DMB_RT_BCO = 3'h0,
      DMB_RT_CBO = 3'h1,
      DMB_RT_BOC = 3'h2,
      DMB_RT_OBC = 3'h3,
      DMB_RT_COB = 3'h4,
      DMB_RT_OCB = 3'h5
   } dmb_route_t;

   typedef enum logic [1:0] {
      DMB_ST_IDLE = 2'h0,
      DMB_ST_SERV = 2'h1
   } dmb_state_t;
endpackage
`default_nettype wire

// >>> verif/dmb_coproc_model.sv
// Purpose: Coprocessor core stand-in that returns from each service routine
// Assumes: A routine starts when coproc_in_service rises
// Notes:   Fixed routine length, so a nested take would show mid-routine
`timescale 1ns/100ps
`default_nettype none
module dmb_coproc_model #(
   parameter int SERV_CYCLES = 16
) (
   // System
   input  wire logic clk_sys,
   input  wire logic resetn,
   // Service handshake
   input  wire logic coproc_in_service,
   output var  logic coproc_isr_done
);
   int cnt;

   // One return pulse per routine, never early
   always_ff @(posedge clk_sys) begin
      if (!resetn || !coproc_in_service || coproc_isr_done) begin
         cnt             <= 0;
         coproc_isr_done <= 1'b0;
      end else begin
         cnt             <= cnt + 1;
         coproc_isr_done <= (cnt == SERV_CYCLES - 1);
      end
   end
endmodule
`default_nettype wire

// >>> verif/dual_cpu_mailbox_interrupts_bench.sv
// Purpose: Directed bench for the mailbox and coprocessor interrupt block
// Assumes: Strobes driven 1 ns after the rising edge, read data next cycle
// Notes:   Routing is checked with the conversion source alone pending
`timescale 1ns/100ps
`default_nettype none
module dual_cpu_mailbox_interrupts_bench;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic        host_mb_wr = 1'b0, host_mb_rd = 1'b0, host_ctrl_wr = 1'b0, host_ctrl_rd = 1'b0;
   logic [3:0]  host_mb_addr = 4'h0, host_ctrl_addr = 4'hc;
   logic [7:0]  host_mb_wdata = 8'h00, host_ctrl_wdata = 8'h00, host_mb_rdata, host_ctrl_rdata;
   logic        host_instr_done = 1'b0, host_doorbell_request;
   logic        coproc_wr = 1'b0, coproc_rd = 1'b0, adc_done = 1'b0, third_timer = 1'b0;
   logic [2:0]  coproc_addr = 3'h0;
   logic [15:0] coproc_wdata = 16'h0000, coproc_rdata, cfg;
   logic        coproc_isr_done, coproc_irq_take, coproc_in_service;
   logic [1:0]  coproc_irq_vector;
   logic [11:0] vtab = 12'h609;
   int          n_fail = 0, n_checks = 0, n_takes = 0, i;

   always #5 clk_sys = ~clk_sys;

   // Every accepted interrupt, nested ones included
   always @(posedge clk_sys) begin
      if (coproc_irq_take === 1'b1) begin
         n_takes++;
      end
   end

   dmb_mailbox u_dmb_mailbox (.clk_sys(clk_sys), .resetn(resetn), .host_mb_wr(host_mb_wr),
      .host_mb_rd(host_mb_rd), .host_mb_addr(host_mb_addr), .host_mb_wdata(host_mb_wdata),
      .host_mb_rdata(host_mb_rdata), .host_ctrl_wr(host_ctrl_wr), .host_ctrl_rd(host_ctrl_rd),
      .host_ctrl_addr(host_ctrl_addr), .host_ctrl_wdata(host_ctrl_wdata), .host_ctrl_rdata(host_ctrl_rdata),
      .host_instr_done(host_instr_done), .host_doorbell_request(host_doorbell_request),
      .coproc_wr(coproc_wr), .coproc_rd(coproc_rd), .coproc_addr(coproc_addr), .coproc_wdata(coproc_wdata),
      .coproc_rdata(coproc_rdata), .adc_done(adc_done), .third_timer(third_timer),
      .coproc_isr_done(coproc_isr_done), .coproc_irq_take(coproc_irq_take),
      .coproc_irq_vector(coproc_irq_vector), .coproc_in_service(coproc_in_service));

   dmb_coproc_model u_dmb_coproc_model (.clk_sys(clk_sys), .resetn(resetn),
      .coproc_in_service(coproc_in_service), .coproc_isr_done(coproc_isr_done));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic hw(input logic [3:0] a, input logic [7:0] d);
      host_mb_wr    = 1'b1;
      host_mb_addr  = a;
      host_mb_wdata = d;
      #10 host_mb_wr = 1'b0;
      #10;
   endtask

   task automatic hr(input logic [3:0] a, input logic [7:0] exp);
      host_mb_rd   = 1'b1;
      host_mb_addr = a;
      #10 host_mb_rd = 1'b0;
      chk("host mailbox byte", {8'h00, host_mb_rdata}, {8'h00, exp});
      #10;
   endtask

   task automatic ctw(input logic [7:0] d);
      host_ctrl_wr    = 1'b1;
      host_ctrl_wdata = d;
      #10 host_ctrl_wr = 1'b0;
      #10;
   endtask

   task automatic ctr(input logic [7:0] exp);
      host_ctrl_rd = 1'b1;
      #10 host_ctrl_rd = 1'b0;
      chk("host control", {8'h00, host_ctrl_rdata}, {8'h00, exp});
      #10;
   endtask

   task automatic cw(input logic [2:0] a, input logic [15:0] d);
      coproc_wr    = 1'b1;
      coproc_addr  = a;
      coproc_wdata = d;
      #10 coproc_wr = 1'b0;
      #10;
   endtask

   task automatic cr(input logic [2:0] a, input logic [15:0] exp);
      coproc_rd   = 1'b1;
      coproc_addr = a;
      #10 coproc_rd = 1'b0;
      chk("coprocessor port", coproc_rdata, exp);
      #10;
   endtask

   // Wait for a take, then check which input was accepted
   task automatic wait_in(input logic [1:0] v);
      for (int k = 0; k < 40 && coproc_in_service !== 1'b1; k++) #10;
      if (coproc_in_service !== 1'b1) begin
         chk("service start", {15'h0, coproc_in_service}, 16'h0001);
         stop_test();
      end
      chk("vector", {14'h0, coproc_irq_vector}, {14'h0, v});
   endtask

   // Vector must hold for the whole routine: a nested take would move it
   task automatic wait_out(input logic [1:0] v);
      for (int k = 0; k < 40 && coproc_in_service === 1'b1; k++) begin
         chk("vector held", {14'h0, coproc_irq_vector}, {14'h0, v});
         chk("take in service", {15'h0, coproc_irq_take}, 16'h0000);
         #10;
      end
      if (coproc_in_service !== 1'b0) begin
         chk("service end", {15'h0, coproc_in_service}, 16'h0000);
         stop_test();
      end
   endtask

   task automatic pulse(input int which);
      if (which == 0) adc_done = 1'b1;
      if (which == 1) third_timer = 1'b1;
      if (which == 2) host_instr_done = 1'b1;
      if (which == 3) {adc_done, third_timer} = 2'b11;
      #10 {adc_done, third_timer, host_instr_done} = 3'b000;
      #10;
   endtask

   initial begin
      repeat (20) @(posedge clk_sys);
      #1 resetn = 1'b1;
      cr(3'h4, 16'h0000);
      ctr(8'h00);
      for (i = 0; i < 8; i++) hw(i[3:0], 8'ha0 + i[7:0]);
      for (i = 0; i < 8; i++) hr(i[3:0], 8'ha0 + i[7:0]);
      for (i = 0; i < 4; i++) cr(i[2:0], {8'ha0 + 8'(2 * i), 8'ha1 + 8'(2 * i)});
      for (i = 0; i < 4; i++) cw(i[2:0], {8'hc0 + i[7:0], 8'hd0 + i[7:0]});
      hw(4'h8, 8'h5a);
      for (i = 0; i < 4; i++) hr(4'h8 + 4'(2 * i), 8'hc0 + i[7:0]);
      for (i = 0; i < 4; i++) hr(4'h9 + 4'(2 * i), 8'hd0 + i[7:0]);
      cr(3'h0, 16'ha0a1);
      $display("test mailbox done");
      cw(3'h4, 16'h1c00);
      pulse(1);
      cw(3'h4, 16'h1900);
      #50 chk("masked in service", {15'h0, coproc_in_service}, 16'h0000);
      cw(3'h4, 16'h1d00);
      wait_in(2'h0);
      cw(3'h4, 16'h3d00);
      wait_out(2'h0);
      for (i = 0; i < 6; i++) begin
         cfg = 16'h1d00 | (16'(i) << 5);
         cw(3'h4, cfg);
         cr(3'h4, cfg);
         pulse(0);
         wait_in(vtab[2 * i +: 2]);
         cw(3'h4, cfg | 16'h4000);
         wait_out(vtab[2 * i +: 2]);
      end
      cw(3'h4, 16'h1dc0);
      pulse(0);
      #50 chk("reserved route", {15'h0, coproc_in_service}, 16'h0000);
      cr(3'h4, 16'h5dc0);
      cw(3'h4, 16'h5d00);
      $display("test routing done");
      cw(3'h4, 16'h1d00);
      pulse(3);
      wait_in(2'h1);
      cw(3'h4, 16'h5d00);
      cr(3'h4, 16'h3d00);
      wait_out(2'h1);
      wait_in(2'h0);
      cw(3'h4, 16'h1d00);
      cr(3'h4, 16'h3d00);
      cw(3'h4, 16'h3d00);
      wait_out(2'h0);
      ctw(8'h02);
      wait_in(2'h2);
      ctr(8'h02);
      cw(3'h4, 16'h9d00);
      wait_out(2'h2);
      ctr(8'h00);
      $display("test priority done");
      cw(3'h4, 16'h0200);
      chk("host request", {15'h0, host_doorbell_request}, 16'h0001);
      cr(3'h4, 16'h0200);
      ctr(8'h01);
      ctw(8'h01);
      pulse(2);
      pulse(2);
      chk("host request held", {15'h0, host_doorbell_request}, 16'h0001);
      pulse(2);
      chk("host request cleared", {15'h0, host_doorbell_request}, 16'h0000);
      host_ctrl_addr = 4'hb;
      ctw(8'h02);
      ctr(8'h00);
      host_ctrl_addr = 4'hc;
      ctr(8'h00);
      $display("test host request done");
      cw(3'h4, 16'h1f00);
      cr(3'h4, 16'h1f00);
      resetn = 1'b0;
      #20 resetn = 1'b1;
      cr(3'h4, 16'h0000);
      ctr(8'h00);
      hr(4'h0, 8'h00);
      $display("test reset done");
      chk("takes", 16'(n_takes), 16'h000a);
      stop_test();
   end
endmodule
`default_nettype wire
